// ==== logic/irq_seq.v ====
// Interrupt entry and return sequencer with eight external channels.
// Assumes the core raises irq_ret for return and pulses ei_op, and that
// it consumes one frame element per frame_ack while frame_valid is high.
// Functional notes
// RULE_01: Acknowledge clears global interrupt enable first.
// RULE_02: Push PC low, high, segment, flags; vector.
// RULE_03: Entry loads segment or substitutes vector segment.
// RULE_04: Return pops flags, segment, PC high, low; enable.
// RULE_05: Concurrent return switches fetch back to code segment.
// RULE_06: Pending requests wait until enable set again.
// RULE_07: Concurrent mode keeps no acknowledged priority.
// RULE_08: Software avoids enable op in concurrent routines.
// RULE_09: Concurrent nesting needs segment save or equality.
// RULE_10: Nested acknowledge sets stack bit at priority.
// RULE_11: Nested acknowledge loads request priority into current.
// RULE_12: Nested entry: disable, save, load, then pushes.
// RULE_13: Nested return restores priority from stack.
// RULE_14: Nested return keeps vector segment if still nested.
// RULE_15: Eight channels; only A0 and D0 have pins.
// RULE_16: Edge select: one rising, zero falling.
// RULE_17: Mask bit seven is A0, zero is D1.
// RULE_18: Pair priority: even channel even, odd next.
// RULE_19: A0 source pin when one, timer otherwise.
// RULE_20: D0 source pin when zero, clock unit otherwise.
// RULE_21: Acknowledge only priority strictly below current.
// RULE_22: Current priority resets to seven.
// RULE_23: Mode select clear concurrent, set nested.
// RULE_24: Restore takes lowest set stack bit, clears it.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "irq_seq_regs.vh"

module irq_seq
(
	input  wire        sys_clk,
	input  wire        sys_rst,
	input  wire        clk_en,        // Low freezes all state.
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	input  wire [31:0] s_axi_araddr,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	input  wire        ext_pin_zero,  // Asynchronous pin for A0.
	input  wire        ext_pin_six,   // Asynchronous pin for D0.
	input  wire        timer_irq,     // Same-clock timer request.
	input  wire        clock_ctrl_irq,// Same-clock clock unit request.
	input  wire        instr_boundary,// Core arbitration point pulse.
	input  wire        irq_ret,       // Core executes return, pulse.
	input  wire        ei_op,         // Core executes enable op, pulse.
	input  wire [15:0] pc_in,         // Program counter to save.
	input  wire [7:0]  flags_in,      // Flags to save.
	input  wire [7:0]  vector_segment,// Interrupt segment register.
	input  wire [7:0]  pop_data,      // Popped stack byte, with frame_ack.
	input  wire        frame_ack,     // Core took the frame element.
	output reg         frame_valid,   // Frame element offered.
	output reg         frame_push,    // One push, zero pop.
	output reg  [1:0]  frame_kind,    // Which element.
	output reg  [7:0]  frame_data,    // Pushed byte.
	output reg  [7:0]  vector_addr,   // Vector table byte address.
	output reg         vector_load,   // Pulse: load PC from vector.
	output reg  [15:0] ret_pc,        // Restored program counter.
	output reg         ret_done,      // Pulse: return finished.
	output reg  [7:0]  code_segment,  // Code segment register.
	output reg         use_vector_seg,// Fetch from vector segment.
	output reg         global_irq_enable
);

	localparam [5:0] ST_IDLE = 6'h01;  // Waiting for a request.
	localparam [5:0] ST_PUSH = 6'h02;  // Pushing the frame.
	localparam [5:0] ST_VECT = 6'h04;  // Issuing the vector.
	localparam [5:0] ST_POP  = 6'h08;  // Popping the frame.
	localparam [5:0] ST_DONE = 6'h10;  // Finishing the return.
	localparam [5:0] ST_RSVD = 6'h20;  // Unused code.

	reg  [5:0] state;            // Sequencer state.
	reg  [1:0] step;             // Current frame element.
	reg  [2:0] current_priority; // Running routine priority.
	reg        arb_mode;         // Zero concurrent, one nested.
	reg  [7:0] nest_stack;       // One bit per saved level.
	reg  [7:0] edge_sel;         // Edge select per channel.
	reg  [7:0] mask_bits;        // Bit 7 is A0, bit 0 is D1.
	reg  [7:0] pair_prio;        // Pair levels in bits 7:6..1:0.
	reg  [2:0] seg_ctrl;         // Save, A0 source, D0 source.
	reg  [6:0] vector_pointer;   // Base vector, bit 0 per channel.
	reg  [2:0] ack_chan;         // Channel taken.
	reg  [7:0] saved_cseg;       // Code segment while pushing.
	reg  [1:0] pin_s0;           // First synchroniser stage.
	reg  [1:0] pin_s1;           // Second synchroniser stage.
	wire [7:0] pend;             // Pending flags, index 0 is A0.
	wire [7:0] src;              // Channel sources.
	reg  [7:0] ack_clr;          // Clear pulse on acknowledge.
	reg  [2:0] best_prio;        // Winning priority.
	reg  [2:0] best_chan;        // Winning channel.
	reg        best_ok;          // Any unmasked pending request.
	reg  [2:0] rest_lvl;         // Level to restore.
	reg  [7:0] pend_wval;        // Software pending write value.
	reg        pend_wr;          // Software pending write strobe.
	integer    i;                // Loop index.

	// Both pins cross into sys_clk through two flip-flops.
	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pin_s0 <= 2'h0;
			pin_s1 <= 2'h0;
		end
		else if (clk_en)
		begin
			pin_s0 <= {ext_pin_six, ext_pin_zero};
			pin_s1 <= pin_s0;
		end
	end

	// Source routing; the other six channels have no source here.
	assign src[0] = seg_ctrl[`SEG_A0_SRC_BIT] ? // RULE_19 RULE_15
	                pin_s1[0] : timer_irq;
	assign src[6] = seg_ctrl[`SEG_D0_SRC_BIT] ? // RULE_20 RULE_15
	                clock_ctrl_irq : pin_s1[1];
	assign src[1] = 1'b0;
	assign src[5:2] = 4'h0;
	assign src[7] = 1'b0;

	// Channel index c uses edge bit c and mask bit 7-c.
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : chan
			edge_pend u_ch
			(
				.sys_clk (sys_clk),
				.sys_rst (sys_rst),
				.clk_en  (clk_en),
				.src     (src[g]),
				.rising  (edge_sel[g]), // RULE_16
				.sw_wr   (pend_wr),
				.sw_val  (pend_wval[g]),
				.hw_clr  (ack_clr[g]),
				.pend    (pend[g])
			);
		end
	endgenerate

	// Arbitration picks the lowest level; lower index breaks ties.
	always @*
	begin
		best_prio = 3'h7;
		best_chan = 3'h0;
		best_ok   = 1'b0;
		for (i = 7; i >= 0; i = i - 1)
			if (pend[i] && mask_bits[7-i] && // RULE_17
			    {pair_prio[7-2*(i/2) -: 2], i[0]} <= best_prio) // RULE_18
			begin
				best_prio = {pair_prio[7-2*(i/2) -: 2], i[0]};
				best_chan = i[2:0];
				best_ok   = 1'b1;
			end
	end

	// Lowest set bit of the nesting stack is the level to restore.
	always @*
	begin
		rest_lvl = 3'h7;
		for (i = 7; i >= 0; i = i - 1)
			if (nest_stack[i])
				rest_lvl = i[2:0]; // RULE_24
	end

	// AXI slave: address and data taken together when both present.
	// Ready stays low while frozen, so no transfer is lost then.
	wire wr_go = clk_en && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	wire rd_go = clk_en && s_axi_arvalid && !s_axi_rvalid;
	wire [7:0] widx = s_axi_awaddr[9:2];
	wire [7:0] ridx = s_axi_araddr[9:2];
	wire       wlo  = s_axi_wstrb[0];
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = rd_go;

	// Software write to the pending register, else a hardware ack clear.
	always @*
	begin
		pend_wr   = clk_en && wr_go && wlo && widx == `IDX_PENDING;
		pend_wval = s_axi_wdata[7:0];
		ack_clr   = 8'h00;
		if (state == ST_IDLE && clk_en && instr_boundary && global_irq_enable
		    && best_ok && best_prio < current_priority)
			ack_clr[best_chan] = 1'b1;
	end

	// Register writes, responses and the interrupt sequence share one
	// process because the sequence also updates software-visible state.
	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RESP_OKAY;
			edge_sel     <= 8'h00;
			mask_bits    <= 8'h00;
			pair_prio    <= 8'h00;
			seg_ctrl     <= `RST_SEG_CTRL;
			vector_pointer <= 7'h00;
			current_priority <= `RST_PRIORITY; // RULE_22
			arb_mode     <= 1'b0; // RULE_23
			global_irq_enable <= 1'b0;
			nest_stack   <= 8'h00;
			state        <= ST_IDLE;
			step         <= 2'h0;
			ack_chan     <= 3'h0;
			saved_cseg   <= 8'h00;
			frame_valid  <= 1'b0;
			frame_push   <= 1'b0;
			frame_kind   <= `FRAME_PC_LO;
			frame_data   <= 8'h00;
			vector_addr  <= 8'h00;
			vector_load  <= 1'b0;
			ret_pc       <= 16'h0000;
			ret_done     <= 1'b0;
			code_segment <= 8'h00;
			use_vector_seg <= 1'b0;
		end
		else if (clk_en)
		begin
			vector_load <= 1'b0;
			ret_done    <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			// Enable op sets enable; pending requests wait for it.
			if (ei_op)
				global_irq_enable <= 1'b1; // RULE_06
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RESP_OKAY;
				if (wlo)
					case (widx)
					`IDX_EDGE_SELECT:   edge_sel  <= s_axi_wdata[7:0];
					`IDX_PAIR_PRIORITY: pair_prio <= s_axi_wdata[7:0];
					`IDX_MASK:          mask_bits <= s_axi_wdata[7:0];
					`IDX_SEG_CTRL:      seg_ctrl  <= s_axi_wdata[2:0];
					`IDX_VECTOR_PTR:    vector_pointer <= s_axi_wdata[7:1];
					`IDX_NEST_STACK:    nest_stack <= s_axi_wdata[7:0];
					`IDX_CENTRAL_CTRL:
					begin
						current_priority <= s_axi_wdata[2:0];
						arb_mode <= s_axi_wdata[`CC_MODE_BIT];
						global_irq_enable <= s_axi_wdata[`CC_ENABLE_BIT];
					end
					`IDX_PENDING, `IDX_SEQ_STATUS: ;
					default: s_axi_bresp <= `RESP_SLVERR;
					endcase
			end
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RESP_OKAY;
				case (ridx)
				`IDX_EDGE_SELECT:   s_axi_rdata <= {24'h00_0000, edge_sel};
				`IDX_PENDING:       s_axi_rdata <= {24'h00_0000, pend};
				`IDX_PAIR_PRIORITY: s_axi_rdata <= {24'h00_0000, pair_prio};
				`IDX_MASK:          s_axi_rdata <= {24'h00_0000, mask_bits};
				`IDX_SEG_CTRL:      s_axi_rdata <= {29'h0000_0000, seg_ctrl};
				`IDX_VECTOR_PTR:
					s_axi_rdata <= {24'h00_0000, vector_pointer, 1'b0};
				`IDX_NEST_STACK:    s_axi_rdata <= {24'h00_0000, nest_stack};
				`IDX_CENTRAL_CTRL:
					s_axi_rdata <= {27'h000_0000, global_irq_enable,
					                arb_mode, current_priority};
				`IDX_SEQ_STATUS:
					s_axi_rdata <= {24'h00_0000, use_vector_seg,
					                1'b0, state};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RESP_SLVERR;
				end
				endcase
			end
			case (state)
			ST_IDLE:
			begin
				if (ack_clr != 8'h00) // RULE_21
				begin
					global_irq_enable <= 1'b0; // RULE_01 RULE_12
					if (arb_mode)
					begin
						nest_stack[current_priority] <= 1'b1; // RULE_10
						current_priority <= best_prio; // RULE_11
					end
					// Concurrent mode keeps no record of best_prio.
					ack_chan    <= best_chan; // RULE_07
					saved_cseg  <= code_segment;
					frame_valid <= 1'b1;
					frame_push  <= 1'b1;
					frame_kind  <= `FRAME_PC_LO;
					frame_data  <= pc_in[7:0];
					step        <= `FRAME_PC_LO;
					state       <= ST_PUSH;
				end
				else if (irq_ret)
				begin
					frame_valid <= 1'b1;
					frame_push  <= 1'b0;
					frame_kind  <= `FRAME_FLAGS;
					step        <= `FRAME_FLAGS;
					state       <= ST_POP;
				end
			end
			ST_PUSH:
			begin
				// Order: PC low, PC high, segment if saved, flags.
				if (frame_ack) // RULE_02
				begin
					case (step)
					`FRAME_PC_LO:
					begin
						step <= `FRAME_PC_HI;
						frame_kind <= `FRAME_PC_HI;
						frame_data <= pc_in[15:8];
					end
					`FRAME_PC_HI:
					begin
						step <= seg_ctrl[`SEG_SAVE_BIT] ?
						        `FRAME_CSEG : `FRAME_FLAGS;
						frame_kind <= seg_ctrl[`SEG_SAVE_BIT] ?
						        `FRAME_CSEG : `FRAME_FLAGS;
						frame_data <= seg_ctrl[`SEG_SAVE_BIT] ?
						        saved_cseg : flags_in;
					end
					`FRAME_CSEG:
					begin
						step <= `FRAME_FLAGS;
						frame_kind <= `FRAME_FLAGS;
						frame_data <= flags_in;
					end
					default:
					begin
						frame_valid <= 1'b0;
						state <= ST_VECT;
					end
					endcase
				end
			end
			ST_VECT:
			begin
				vector_addr <= {vector_pointer, ack_chan[0]};
				vector_load <= 1'b1; // RULE_02
				if (seg_ctrl[`SEG_SAVE_BIT])
					code_segment <= vector_segment; // RULE_03
				else
					use_vector_seg <= 1'b1; // RULE_03
				state <= ST_IDLE;
			end
			ST_POP:
			begin
				// Order: flags, segment if saved, PC high, PC low.
				if (frame_ack) // RULE_04
				begin
					case (step)
					`FRAME_FLAGS:
					begin
						step <= seg_ctrl[`SEG_SAVE_BIT] ?
						        `FRAME_CSEG : `FRAME_PC_HI;
						frame_kind <= seg_ctrl[`SEG_SAVE_BIT] ?
						        `FRAME_CSEG : `FRAME_PC_HI;
					end
					`FRAME_CSEG:
					begin
						code_segment <= pop_data;
						step <= `FRAME_PC_HI;
						frame_kind <= `FRAME_PC_HI;
					end
					`FRAME_PC_HI:
					begin
						ret_pc[15:8] <= pop_data;
						step <= `FRAME_PC_LO;
						frame_kind <= `FRAME_PC_LO;
					end
					default:
					begin
						ret_pc[7:0] <= pop_data;
						frame_valid <= 1'b0;
						state <= ST_DONE;
					end
					endcase
				end
			end
			ST_DONE:
			begin
				global_irq_enable <= 1'b1; // RULE_04
				ret_done <= 1'b1;
				if (arb_mode)
				begin
					current_priority <= rest_lvl; // RULE_13
					nest_stack[rest_lvl] <= 1'b0; // RULE_24
					// Stay on vector segment if returning into a routine.
					if (rest_lvl == 3'h7)
						use_vector_seg <= 1'b0; // RULE_14
				end
				else
					use_vector_seg <= 1'b0; // RULE_05
				state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

endmodule

// ==== logic/irq_seq_regs.vh ====
// Register offsets, field positions, reset values and sequence codes
// for the interrupt sequencer and external interrupt block.
// Assumes AXI4-Lite byte addressing with one 32-bit word per register.
`ifndef IRQ_SEQ_REGS_VH
`define IRQ_SEQ_REGS_VH

// Printed offsets are not all multiples of four: they are indexes.
`define IDX_EDGE_SELECT       8'hF2
`define IDX_PENDING           8'hF3
`define IDX_PAIR_PRIORITY     8'hF5
`define IDX_MASK              8'hF6
`define IDX_CENTRAL_CTRL      8'hE6
`define IDX_NEST_STACK        8'hF7
`define IDX_SEG_CTRL          8'hF8
`define IDX_VECTOR_PTR        8'hF9
`define IDX_SEQ_STATUS        8'hFA
// Central control fields.
`define CC_PRIO_LSB           0
`define CC_MODE_BIT           3
`define CC_ENABLE_BIT         4
// Segment control fields.
`define SEG_SAVE_BIT          0
`define SEG_A0_SRC_BIT        1
`define SEG_D0_SRC_BIT        2
// Reset values.
`define RST_PRIORITY          3'h7
`define RST_SEG_CTRL          3'h2
// Stack frame element codes for the core.
`define FRAME_PC_LO           2'h0
`define FRAME_PC_HI           2'h1
`define FRAME_CSEG            2'h2
`define FRAME_FLAGS           2'h3
// AXI responses.
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

// ==== logic/edge_pend.v ====
// One external interrupt channel: edge detector and pending flag.
// Assumes its input is already synchronised to sys_clk.
`timescale 1ns/1ps

module edge_pend
(
	input  wire sys_clk,
	input  wire sys_rst,
	input  wire clk_en,
	input  wire src,       // Synchronised source level.
	input  wire rising,    // One selects rising edges, zero falling.
	input  wire sw_wr,     // Software writes the pending bit.
	input  wire sw_val,    // Value written by software.
	input  wire hw_clr,    // Acknowledge clears the pending bit.
	output reg  pend       // Pending flag.
);

	reg  src_d;            // Previous source level for edge detection.
	wire hit;              // Selected edge seen this cycle.

	assign hit = rising ? (src & ~src_d) : (~src & src_d);

	// The edge wins over any clear in the same cycle, so no event is lost.
	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			src_d <= 1'b0;
			pend  <= 1'b0;
		end
		else if (clk_en)
		begin
			src_d <= src;
			if (hit)
				pend <= 1'b1;
			else if (sw_wr)
				pend <= sw_val;
			else if (hw_clr)
				pend <= 1'b0;
		end
	end

endmodule

// ==== tb/irq_seq_monitor.sv ====
// Checker for the interrupt sequencer: frame order, enable and fetch
// segment handling. Sees only the top ports and is bound below.
`timescale 1ns/1ps
`include "irq_seq_regs.vh"

module irq_seq_monitor
(
	input wire        sys_clk,
	input wire        sys_rst,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire        frame_valid,
	input wire        frame_push,
	input wire [1:0]  frame_kind,
	input wire        frame_ack,
	input wire        vector_load,
	input wire        ret_done,
	input wire        use_vector_seg,
	input wire        global_irq_enable
);
	// One clock domain, so clock and reset are given once here.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_off; frame_valid && frame_push |-> !global_irq_enable;
	endproperty
	a_off: assert property (p_off) else $error("Enable high in entry.");
	property p_armed; $rose(frame_valid) && frame_push |->
		$past(global_irq_enable); endproperty
	a_armed: assert property (p_armed) else $error("Entry while off.");
	property p_hi; frame_ack && frame_valid && frame_push &&
		frame_kind == `FRAME_PC_LO |-> ##[1:2] frame_valid &&
		frame_push && frame_kind == `FRAME_PC_HI; endproperty
	a_hi: assert property (p_hi) else $error("High byte missing.");
	property p_vec; frame_ack && frame_valid && frame_push &&
		frame_kind == `FRAME_FLAGS |-> ##[1:3] vector_load; endproperty
	a_vec: assert property (p_vec) else $error("Vector load late.");
	// An offered element must not change under a slow core.
	property p_hold; frame_valid && !frame_ack |=> frame_valid &&
		$stable(frame_kind) && $stable(frame_push); endproperty
	a_hold: assert property (p_hold) else $error("Element changed.");
	property p_pop1; $rose(frame_valid) && !frame_push |->
		frame_kind == `FRAME_FLAGS; endproperty
	a_pop1: assert property (p_pop1) else $error("Flags not first.");
	property p_lo; frame_ack && frame_valid && !frame_push &&
		frame_kind == `FRAME_PC_HI |-> ##[1:2] frame_valid &&
		!frame_push && frame_kind == `FRAME_PC_LO; endproperty
	a_lo: assert property (p_lo) else $error("Low byte not last.");
	property p_ren; $rose(ret_done) |-> ##[0:1] global_irq_enable;
	endproperty
	a_ren: assert property (p_ren) else $error("Return left off.");
	property p_back; $fell(use_vector_seg) |-> ret_done ||
		$past(ret_done) || $past(ret_done, 2); endproperty
	a_back: assert property (p_back) else $error("Segment swap.");
	property p_vseg; $rose(use_vector_seg) |-> !global_irq_enable;
	endproperty
	a_vseg: assert property (p_vseg) else $error("Segment early.");
	property p_rd; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
		$stable(s_axi_rdata); endproperty
	a_rd: assert property (p_rd) else $error("Read data dropped.");
endmodule

bind irq_seq irq_seq_monitor irq_seq_monitor_inst (.*);

// ==== tb/core_model.sv ====
// Behavioural core stack: takes pushed bytes and pops them back.
// Assumes one element per frame_ack, sampled at the rising edge.
`timescale 1ns/1ps

module core_model
(
	input  wire       sys_clk,
	input  wire       sys_rst,
	input  wire       frame_valid,
	input  wire       frame_push,
	input  wire [7:0] frame_data,
	output reg        frame_ack,
	output reg  [7:0] pop_data
);
	reg     [7:0] stk [0:7]; // System stack bytes.
	integer       sp;        // Count of bytes on the stack.
	integer       seed = 91187;

	// Random delay before each acknowledge covers prompt and slow cores.
	// Off the acknowledge the pop bus toggles, so a stale byte is wrong.
	always @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			frame_ack <= 1'h0;
			pop_data <= 8'h00;
			sp = 0;
		end
		else if (frame_ack)
		begin
			frame_ack <= 1'h0;
			pop_data <= ~pop_data;
			if (frame_push)
			begin
				stk[sp] = frame_data;
				sp = sp + 1;
			end
			else if (sp > 0)
				sp = sp - 1;
		end
		else if (frame_valid && $random(seed) % 2)
		begin
			frame_ack <= 1'h1;
			pop_data <= frame_push ? ~pop_data : stk[sp - 1];
		end
		else
			pop_data <= ~pop_data;
	end
endmodule

// ==== tb/interrupt_entry_exit_and_ext_irq_test.sv ====
// Self-checking bench: register bus, entry and return in both modes.
// Assumes the sequencer, its register header and the core model.
`timescale 1ns/1ps
`include "irq_seq_regs.vh"

module interrupt_entry_exit_and_ext_irq_test;
	reg         sys_clk, sys_rst, clk_en, instr_boundary, irq_ret, ei_op;
	reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	reg         s_axi_arvalid, s_axi_rready;
	reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
	reg  [3:0]  s_axi_wstrb;
	reg         ext_pin_zero, ext_pin_six, timer_irq, clock_ctrl_irq;
	reg  [15:0] pc_in, pc1, pc2;
	reg  [7:0]  flags_in, vector_segment, v;
	wire [7:0]  pop_data, frame_data, vector_addr, code_segment;
	wire        frame_ack, frame_valid, frame_push, vector_load, ret_done;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire        s_axi_rvalid, use_vector_seg, global_irq_enable;
	wire [1:0]  s_axi_bresp, s_axi_rresp, frame_kind;
	wire [31:0] s_axi_rdata;
	wire [15:0] ret_pc;
	integer     seed = 91187;
	integer     error_cnt = 0;
	integer     tests_run = 0;
	integer     vec_cnt = 0; // Vector loads seen so far.
	integer     n0;
	reg  [31:0] d;
	reg  [1:0]  r, p, q;

	irq_seq irq_seq_inst (.*);
	core_model core_model_inst (.*);

	// Clock at 250 MHz.
	initial
	begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Arbitration points arrive at random, as instructions of mixed length.
	always @(posedge sys_clk)
	begin
		instr_boundary <= $random(seed) % 2;
		if (vector_load === 1'h1)
			vec_cnt = vec_cnt + 1;
	end

	// The whole run needs well under this many cycles.
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		error_cnt = error_cnt + 1;
		give_verdict;
	end

	task give_verdict;
	begin
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	task chk(input [31:0] got, input [31:0] exp);
	begin
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask

	// Address and data go out together; each register is index times four.
	task axi_wr(input [7:0] idx, input [31:0] wd);
	begin
		@(posedge sys_clk);
		s_axi_awaddr <= {22'h0, idx, 2'h0};
		s_axi_wdata <= wd;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		@(posedge sys_clk);
		// Each channel is released at its own ready; bready waits for bvalid.
		while (s_axi_awvalid || s_axi_wvalid || s_axi_bvalid !== 1'h1)
		begin
			if (s_axi_awready === 1'h1)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1)
				s_axi_wvalid <= 1'h0;
			@(posedge sys_clk);
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	end
	endtask

	task axi_rd(input [7:0] idx);
	begin
		@(posedge sys_clk);
		s_axi_araddr <= {22'h0, idx, 2'h0};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		@(posedge sys_clk);
		while (s_axi_arready !== 1'h1) @(posedge sys_clk);
		s_axi_arvalid <= 1'h0;
		while (s_axi_rvalid !== 1'h1) @(posedge sys_clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	end
	endtask

	task rdchk(input [7:0] idx, input [31:0] exp);
	begin
		axi_rd(idx);
		chk({d[31:0]}, exp);
	end
	endtask

	// One-cycle core pulses, then waits on the sequencer's answer.
	task pulse_ei;
	begin
		@(posedge sys_clk);
		ei_op <= 1'h1;
		@(posedge sys_clk);
		ei_op <= 1'h0;
		while (vector_load !== 1'h1) @(posedge sys_clk);
	end
	endtask

	task do_ret;
	begin
		@(posedge sys_clk);
		irq_ret <= 1'h1;
		@(posedge sys_clk);
		irq_ret <= 1'h0;
		while (ret_done !== 1'h1) @(posedge sys_clk);
	end
	endtask

	initial
	begin
		{sys_rst, clk_en, s_axi_wstrb} = 6'h3F;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, irq_ret, ei_op} = 4'h0;
		{ext_pin_zero, ext_pin_six, timer_irq, clock_ctrl_irq} = 4'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		pc1 = $random(seed);
		pc2 = $random(seed);
		v = $random(seed);
		p = (($random(seed) & 32'h7FFF_FFFF) % 3);
		q = (($random(seed) & 32'h7FFF_FFFF) % 3);
		{pc_in, flags_in, vector_segment} = {pc1, v ^ 8'h5A, v | 8'h01};
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'h0;
		rdchk(`IDX_CENTRAL_CTRL, 32'h0000_0007);
		rdchk(`IDX_SEG_CTRL, 32'h0000_0002);
		axi_rd(8'h10);
		chk(r, `RESP_SLVERR);
		axi_wr(8'h10, 32'h0000_00FF);
		chk(r, `RESP_SLVERR);
		$display("Reset and map test finished");
		// Concurrent mode, no segment save, falling edge on the A0 pin.
		axi_wr(`IDX_EDGE_SELECT, 32'h0000_0000);
		chk(r, `RESP_OKAY);
		axi_wr(`IDX_MASK, 32'h0000_0000);
		axi_wr(`IDX_PAIR_PRIORITY, {24'h0, p, 6'h0});
		axi_wr(`IDX_VECTOR_PTR, {24'h0, v});
		ext_pin_zero <= 1'h1;
		repeat (8) @(posedge sys_clk);
		rdchk(`IDX_PENDING, 32'h0000_0000);
		ext_pin_zero <= 1'h0;
		repeat (8) @(posedge sys_clk);
		rdchk(`IDX_PENDING, 32'h0000_0001);
		axi_wr(`IDX_MASK, 32'h0000_0080);
		pulse_ei;
		chk(global_irq_enable, 0);
		chk(vector_addr, {v[7:1], 1'h0});
		chk(use_vector_seg, 1);
		chk(core_model_inst.sp, 3);
		chk({core_model_inst.stk[1], core_model_inst.stk[0]}, pc1);
		chk(core_model_inst.stk[2], v ^ 8'h5A);
		rdchk(`IDX_CENTRAL_CTRL, 32'h0000_0007);
		// A request raised inside the routine waits for the enable.
		axi_wr(`IDX_MASK, 32'h0000_00C0);
		axi_wr(`IDX_PENDING, 32'h0000_0002);
		n0 = vec_cnt;
		repeat (20) @(posedge sys_clk);
		chk(vec_cnt, n0);
		// No enable op inside a concurrent routine, so no nesting there;
		// the return itself re-enables and the waiting request follows.
		pc_in <= pc2;
		do_ret;
		chk(ret_pc, pc1);
		chk(use_vector_seg, 0);
		while (vector_load !== 1'h1) @(posedge sys_clk);
		chk(vector_addr, {v[7:1], 1'h1});
		do_ret;
		chk(ret_pc, pc2);
		rdchk(`IDX_CENTRAL_CTRL, 32'h0000_0017);
		$display("Concurrent mode test finished");
		// Nested mode with segment save, D0 fed by the clock unit.
		axi_wr(`IDX_SEG_CTRL, 32'h0000_0007);
		axi_wr(`IDX_CENTRAL_CTRL, 32'h0000_000F);
		axi_wr(`IDX_EDGE_SELECT, 32'h0000_0040);
		axi_wr(`IDX_PENDING, 32'h0000_0000);
		axi_wr(`IDX_MASK, 32'h0000_0002);
		axi_wr(`IDX_PAIR_PRIORITY, {24'h0, p, 4'h0, q});
		pc_in <= pc2 ^ 16'hA5A5;
		clock_ctrl_irq <= 1'h1;
		pulse_ei;
		chk(vector_addr, {v[7:1], 1'h0});
		chk(code_segment, v | 8'h01);
		chk(core_model_inst.sp, 4);
		chk(core_model_inst.stk[2], 8'h00);
		rdchk(`IDX_CENTRAL_CTRL, {28'h0, 1'h1, q, 1'h0});
		rdchk(`IDX_NEST_STACK, 32'h0000_0080);
		clock_ctrl_irq <= 1'h0;
		do_ret;
		chk(ret_pc, pc2 ^ 16'hA5A5);
		chk(code_segment, 8'h00);
		chk(use_vector_seg, 0);
		rdchk(`IDX_CENTRAL_CTRL, 32'h0000_001F);
		rdchk(`IDX_NEST_STACK, 32'h0000_0000);
		// Level seven can never beat the current level of seven.
		axi_wr(`IDX_PAIR_PRIORITY, 32'h0000_00C0);
		axi_wr(`IDX_MASK, 32'h0000_0040);
		n0 = vec_cnt;
		axi_wr(`IDX_PENDING, 32'h0000_0002);
		repeat (30) @(posedge sys_clk);
		chk(vec_cnt, n0);
		rdchk(`IDX_PENDING, 32'h0000_0002);
		$display("Nested mode test finished");
		give_verdict;
	end
endmodule
